// ===== shared/tmr8_regs.svh
// Register offsets, field positions, reset values and counter limits
`ifndef TMR8_REGS_SVH
`define TMR8_REGS_SVH
`define TMR8_OFF_CTRL 8'h00
`define TMR8_OFF_COUNT 8'h04
`define TMR8_OFF_COMPARE 8'h08
`define TMR8_OFF_FLAGS 8'h0c
`define TMR8_OFF_IRQEN 8'h10
`define TMR8_OFF_ASYNC 8'h14
`define TMR8_OFF_PORT 8'h18
`define TMR8_CTRL_CS_LSB 0
`define TMR8_CTRL_COM_LSB 4
`define TMR8_CTRL_WAVE_LSB 6
`define TMR8_CTRL_FORCE_BIT 8
`define TMR8_FLAG_OVF_BIT 0
`define TMR8_FLAG_CMP_BIT 1
`define TMR8_PORT_DIR_BIT 0
`define TMR8_PORT_DATA_BIT 1
`define TMR8_RST_CTRL 8'h00
`define TMR8_RST_BYTE 8'h00
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff
`endif

// ===== shared/tmr8_pkg.sv
// Types shared by the timer design files
package tmr8_pkg;
    typedef enum logic [1:0] {
        TMR8_NORMAL = 2'b00,
        TMR8_FAST_PWM = 2'b01,
        TMR8_CTC = 2'b10,
        TMR8_PHASE_PWM = 2'b11
    } tmr8_wave_e;

    typedef struct packed {
        tmr8_wave_e waveformMode;
        logic [1:0] compareOutputMode;
        logic spare;
        logic [2:0] clockSelect;
    } tmr8_ctrl_s;
endpackage : tmr8_pkg

// ===== hdl/tmr8_sync.sv
// Two-flop synchroniser for a pin level
`timescale 1ns/1ps
module tmr8_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic pinLevel,
    output logic syncLevel
);
    logic stage1;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= 1'b0;
            syncLevel <= 1'b0;
        end else begin
            stage1 <= pinLevel;
            syncLevel <= stage1;
        end
    end
endmodule : tmr8_sync

// ===== hdl/tmr8_prescaler.sv
// Prescaler turning base ticks into the timer clock enable
`timescale 1ns/1ps
module tmr8_prescaler (
    input wire logic clk,
    input wire logic rst,
    input wire logic baseTick,
    input wire logic [2:0] clockSelect,
    output logic tick
);
    logic [9:0] divider;
    logic [9:0] mask;

    assign mask = (clockSelect == 3'h2) ? 10'h007 :
                  (clockSelect == 3'h3) ? 10'h01f :
                  (clockSelect == 3'h4) ? 10'h03f :
                  (clockSelect == 3'h5) ? 10'h07f :
                  (clockSelect == 3'h6) ? 10'h0ff :
                  (clockSelect == 3'h7) ? 10'h3ff : 10'h000;
    // Zero select means no timer clock at all
    assign tick = (clockSelect != 3'h0) && baseTick &&
                  ((divider & mask) == mask);

    always_ff @(posedge clk) begin
        if (rst) begin
            divider <= 10'h000;
        end else if (baseTick) begin
            divider <= divider + 10'h001;
        end
    end
endmodule : tmr8_prescaler

// ===== hdl/tmr8_timer.sv
// 8-bit timer with compare unit, waveform output and APB registers
//
// Contract
// RULE_01: Timer clock is the I/O clock unless async select picks oscillator.
// RULE_02: Each timer tick clears, increments or decrements counter per mode.
// RULE_03: Clock select zero stops the counter, value held.
// RULE_04: Software reads and writes the counter at any time.
// RULE_05: A software counter write beats any clear or count.
// RULE_06: The two waveform mode bits select the counting sequence.
// RULE_07: Overflow flag set at the mode's point and can request interrupt.
// RULE_08: Comparator flags a match whenever counter equals compare value.
// RULE_09: Compare flag set on the timer tick after the match.
// RULE_10: Enabled compare flag raises interrupt; cleared by ack or write one.
// RULE_11: Waveform output built from match, mode bits, max and bottom.
// RULE_12: Compare value double buffered in PWM modes, updated at top/bottom.
// RULE_13: Software reaches buffer when buffered, else the active compare.
// RULE_14: Force strobe acts as match on output only, non-PWM modes.
// RULE_15: Counter write blocks any match on the next timer tick.
// RULE_16: Software avoids writing counter equal compare, or zero downcounting.
// RULE_17: Compare output state kept across waveform mode changes.
// RULE_18: Compare output mode bits unbuffered, effective immediately.
// RULE_19: Output mode bits set next-match action and pin source.
// RULE_20: Nonzero output mode overrides the general port output.
// RULE_21: Pin direction stays with the direction bit.
// RULE_22: Software sets output state before enabling pin as output.
// RULE_23: Bottom is 0x00, max 0xff, top max or compare value.
// RULE_24: Mode 0 normal, 2 clear on match, 1 fast PWM.
// RULE_25: Output mode zero means no action on the output state.
`timescale 1ns/1ps
`include "tmr8_regs.svh"
module tmr8_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic overflowAck,
    input wire logic compareAck,
    input wire logic oscPinIn,
    output logic oscPinOut,
    output logic compareOutput,
    output logic compareOutputOe,
    output logic irq
);
    tmr8_pkg::tmr8_ctrl_s ctrl;
    logic [7:0] counterValue;
    logic [7:0] compareValue;
    logic [7:0] compareBuffer;
    logic countDown;
    logic blockPend;
    logic overflowFlag;
    logic compareFlag;
    logic overflowIrqEnable;
    logic compareIrqEnable;
    logic asyncClockSelect;
    logic outputDirectionBit;
    logic portData;
    logic ocState;
    logic oscSync;
    logic oscPrev;
    logic baseTick;
    logic tick;

    // Bus decode
    logic setupPhase;
    logic wrEn;
    logic selCtrl;
    logic selCount;
    logic selCompare;
    logic selFlags;
    logic selIrqEn;
    logic selAsync;
    logic selPort;
    logic mapped;
    logic [31:0] readMux;

    assign setupPhase = psel && !penable;
    assign wrEn = psel && penable && pwrite && pready && !pslverr;
    assign selCtrl = (paddr == `TMR8_OFF_CTRL);
    assign selCount = (paddr == `TMR8_OFF_COUNT);
    assign selCompare = (paddr == `TMR8_OFF_COMPARE);
    assign selFlags = (paddr == `TMR8_OFF_FLAGS);
    assign selIrqEn = (paddr == `TMR8_OFF_IRQEN);
    assign selAsync = (paddr == `TMR8_OFF_ASYNC);
    assign selPort = (paddr == `TMR8_OFF_PORT);
    assign mapped = selCtrl || selCount || selCompare || selFlags ||
                    selIrqEn || selAsync || selPort;

    logic pwmMode;
    logic ctrlWr;
    logic cntWr;
    logic cmpWr;
    logic flagWr;
    logic forceEv;

    assign pwmMode = (ctrl.waveformMode == tmr8_pkg::TMR8_FAST_PWM) ||
                     (ctrl.waveformMode == tmr8_pkg::TMR8_PHASE_PWM);
    assign ctrlWr = wrEn && selCtrl;
    assign cntWr = wrEn && selCount;
    assign cmpWr = wrEn && selCompare;
    assign flagWr = wrEn && selFlags;
    assign forceEv = ctrlWr && pwdata[`TMR8_CTRL_FORCE_BIT] &&
                     !pwmMode; // RULE_14

    // Read data; compare reads follow the buffering state
    assign readMux =
        selCtrl ? {24'h000000, ctrl} :
        selCount ? {24'h000000, counterValue} : // RULE_04
        selCompare ? {24'h000000, pwmMode ? compareBuffer : compareValue} :
        selFlags ? {30'h00000000, compareFlag, overflowFlag} :
        selIrqEn ? {30'h00000000, compareIrqEnable, overflowIrqEnable} :
        selAsync ? {31'h00000000, asyncClockSelect} :
        selPort ? {30'h00000000, portData, outputDirectionBit} :
        32'h00000000;

    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase && !mapped;
            prdata <= setupPhase ? readMux : 32'h00000000;
        end
    end

    // Timer clock source
    tmr8_sync u_oscSync (
        .clk(clk),
        .rst(rst),
        .pinLevel(oscPinIn),
        .syncLevel(oscSync)
    );

    assign baseTick = asyncClockSelect ? (oscSync && !oscPrev) : 1'b1; // RULE_01

    tmr8_prescaler u_prescaler (
        .clk(clk),
        .rst(rst),
        .baseTick(baseTick),
        .clockSelect(ctrl.clockSelect),
        .tick(tick)
    );

    // Counter and compare events
    logic match;
    logic matchEv;
    logic atMax;
    logic atBottom;
    logic ctcClear;
    logic wrapEv;
    logic bufferUpdate;
    logic overflowEv;
    logic [7:0] next_counter;
    logic next_down;

    assign match = (counterValue == compareValue); // RULE_08
    assign matchEv = tick && match && !blockPend; // RULE_15
    assign atMax = (counterValue == `TMR8_MAX); // RULE_23
    assign atBottom = (counterValue == `TMR8_BOTTOM);
    assign ctcClear = (ctrl.waveformMode == tmr8_pkg::TMR8_CTC) && matchEv;
    assign wrapEv = tick && atMax &&
                    (ctrl.waveformMode != tmr8_pkg::TMR8_PHASE_PWM);
    assign bufferUpdate = pwmMode && tick && atMax; // RULE_12
    assign overflowEv =
        (ctrl.waveformMode == tmr8_pkg::TMR8_PHASE_PWM) ?
        (tick && atBottom && countDown) : wrapEv; // RULE_07

    // Sequence chosen by the waveform mode bits
    always_comb begin
        next_counter = counterValue;
        next_down = countDown;
        if (tick) begin
            case (ctrl.waveformMode) // RULE_06 RULE_24
                tmr8_pkg::TMR8_CTC: begin
                    next_down = 1'b0;
                    next_counter = ctcClear ? `TMR8_BOTTOM :
                                   counterValue + 8'h01; // RULE_02
                end
                tmr8_pkg::TMR8_PHASE_PWM: begin
                    if (!countDown && atMax) begin
                        next_down = 1'b1;
                        next_counter = counterValue - 8'h01;
                    end else if (countDown && atBottom) begin
                        next_down = 1'b0;
                        next_counter = counterValue + 8'h01;
                    end else if (countDown) begin
                        next_counter = counterValue - 8'h01;
                    end else begin
                        next_counter = counterValue + 8'h01;
                    end
                end
                default: begin
                    next_down = 1'b0;
                    next_counter = counterValue + 8'h01;
                end
            endcase
        end
        if (cntWr) begin
            next_counter = pwdata[7:0]; // RULE_05
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            counterValue <= `TMR8_RST_BYTE;
            countDown <= 1'b0;
            blockPend <= 1'b0;
            oscPrev <= 1'b0;
            oscPinOut <= 1'b0;
        end else begin
            counterValue <= next_counter; // RULE_03
            countDown <= next_down;
            blockPend <= cntWr || (blockPend && !tick); // RULE_15
            oscPrev <= oscSync;
            oscPinOut <= asyncClockSelect && !oscSync;
        end
    end

    // Control registers; compare writes go where buffering says
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= `TMR8_RST_CTRL;
            compareValue <= `TMR8_RST_BYTE;
            compareBuffer <= `TMR8_RST_BYTE;
            overflowIrqEnable <= 1'b0;
            compareIrqEnable <= 1'b0;
            asyncClockSelect <= 1'b0;
            outputDirectionBit <= 1'b0;
            portData <= 1'b0;
        end else begin
            if (ctrlWr) begin
                ctrl <= pwdata[7:0]; // RULE_18
            end
            if (cmpWr) begin
                compareBuffer <= pwdata[7:0]; // RULE_13
            end
            if (cmpWr && !pwmMode) begin
                compareValue <= pwdata[7:0]; // RULE_13
            end else if (bufferUpdate) begin
                compareValue <= compareBuffer; // RULE_12
            end
            if (wrEn && selIrqEn) begin
                overflowIrqEnable <= pwdata[`TMR8_FLAG_OVF_BIT];
                compareIrqEnable <= pwdata[`TMR8_FLAG_CMP_BIT];
            end
            if (wrEn && selAsync) begin
                asyncClockSelect <= pwdata[0]; // RULE_01
            end
            if (wrEn && selPort) begin
                outputDirectionBit <= pwdata[`TMR8_PORT_DIR_BIT];
                portData <= pwdata[`TMR8_PORT_DATA_BIT];
            end
        end
    end

    // Flags: a set in the same cycle as a clear wins
    logic ovfClr;
    logic cmpClr;

    assign ovfClr = overflowAck || (flagWr && pwdata[`TMR8_FLAG_OVF_BIT]);
    assign cmpClr = compareAck || (flagWr && pwdata[`TMR8_FLAG_CMP_BIT]);

    always_ff @(posedge clk) begin
        if (rst) begin
            overflowFlag <= 1'b0;
            compareFlag <= 1'b0;
            irq <= 1'b0;
        end else begin
            overflowFlag <= overflowEv || (overflowFlag && !ovfClr); // RULE_07
            compareFlag <= matchEv || (compareFlag && !cmpClr); // RULE_09 RULE_10
            irq <= (compareFlag && compareIrqEnable) ||
                   (overflowFlag && overflowIrqEnable); // RULE_10
        end
    end

    // Waveform generator
    logic [1:0] com;
    logic [1:0] forceCom;
    logic matchAct;
    logic next_oc;

    assign com = ctrl.compareOutputMode;
    // A force acts with the output mode written beside it
    assign forceCom = forceEv ? pwdata[`TMR8_CTRL_COM_LSB +: 2] : com; // RULE_18
    assign matchAct = matchEv || forceEv; // RULE_14

    always_comb begin
        next_oc = ocState; // RULE_17 RULE_25
        case (ctrl.waveformMode) // RULE_11
            tmr8_pkg::TMR8_FAST_PWM: begin
                if (wrapEv && com[1]) begin
                    next_oc = !com[0];
                end else if (matchEv && com[1]) begin
                    next_oc = com[0];
                end else if (matchEv && com == 2'b01) begin
                    next_oc = !ocState;
                end
            end
            tmr8_pkg::TMR8_PHASE_PWM: begin
                if (matchEv && com[1]) begin
                    next_oc = com[0] ^ countDown;
                end
            end
            default: begin
                if (matchAct) begin
                    case (forceCom) // RULE_19
                        2'b01: next_oc = !ocState;
                        2'b10: next_oc = 1'b0;
                        2'b11: next_oc = 1'b1;
                        default: next_oc = ocState;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ocState <= 1'b0;
            compareOutput <= 1'b0;
            compareOutputOe <= 1'b0;
        end else begin
            ocState <= next_oc;
            compareOutput <= (com != 2'b00) ? ocState : portData; // RULE_20
            compareOutputOe <= outputDirectionBit; // RULE_21
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_write_then_tick;
        cntWr ##1 (tick && !cntWr && !flagWr && !compareAck);
    endsequence

    property p_flag_after_match;
        (tick && match && !blockPend) |=> compareFlag;
    endproperty
    a_flag_after_match: assert property (p_flag_after_match) // RULE_09
        else $error("compare flag missed after match");

    property p_stopped;
        (ctrl.clockSelect == 3'h0 && !cntWr) |=>
            (counterValue == $past(counterValue));
    endproperty
    a_stopped: assert property (p_stopped) // RULE_03
        else $error("counter moved with no clock selected");

    property p_write_wins;
        cntWr |=> (counterValue == $past(pwdata[7:0]));
    endproperty
    a_write_wins: assert property (p_write_wins) // RULE_05
        else $error("counter write lost");

    property p_block;
        s_write_then_tick |=> (compareFlag == $past(compareFlag));
    endproperty
    a_block: assert property (p_block) // RULE_15
        else $error("match not blocked after counter write");

    property p_force_no_flag;
        (forceEv && !matchEv && !compareFlag) |=> !compareFlag;
    endproperty
    a_force_no_flag: assert property (p_force_no_flag) // RULE_14
        else $error("force strobe set compare flag");

    property p_ctc_clear;
        (ctcClear && !cntWr) |=> (counterValue == `TMR8_BOTTOM);
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) // RULE_24
        else $error("clear on match failed");

    property p_normal_wrap;
        (ctrl.waveformMode == tmr8_pkg::TMR8_NORMAL && tick && atMax &&
            !cntWr) |=> (overflowFlag && counterValue == `TMR8_BOTTOM);
    endproperty
    a_normal_wrap: assert property (p_normal_wrap) // RULE_07
        else $error("overflow not flagged on wrap");

    property p_buffer_hold;
        (pwmMode && cmpWr && !bufferUpdate) |=>
            (compareValue == $past(compareValue));
    endproperty
    a_buffer_hold: assert property (p_buffer_hold) // RULE_12
        else $error("active compare changed outside update point");

    property p_pin_source;
        (com != 2'b00) |=> (compareOutput == $past(ocState));
    endproperty
    a_pin_source: assert property (p_pin_source) // RULE_20
        else $error("pin not driven by compare state");

    property p_direction;
        !outputDirectionBit |=> !compareOutputOe;
    endproperty
    a_direction: assert property (p_direction) // RULE_21
        else $error("pin enabled without direction bit");

    property p_irq;
        (compareFlag && compareIrqEnable) |=> irq;
    endproperty
    a_irq: assert property (p_irq) // RULE_10
        else $error("compare interrupt not raised");
endmodule : tmr8_timer

// ===== bench/tmr8_core_model.sv
// Processor-side model: APB master and interrupt acknowledges
`timescale 1ns/1ps
module tmr8_core_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic overflowAck,
    output logic compareAck
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        overflowAck = 1'b0;
        compareAck = 1'b0;
    end

    // Request held until pready is seen high at a rising edge
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // One-cycle acknowledge pulses, as the core gives on vector entry
    task ack(input logic ovf, input logic cmp);
        @(posedge clk);
        overflowAck <= ovf;
        compareAck <= cmp;
        @(posedge clk);
        overflowAck <= 1'b0;
        compareAck <= 1'b0;
    endtask : ack
endmodule : tmr8_core_model

// ===== bench/tb.sv
// Self-checking bench for the 8-bit timer
`timescale 1ns/1ps
`include "tmr8_regs.svh"
module tb;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic err;
    } tmr8_row_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, overflowAck, compareAck;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic oscPinIn = 1'b0;
    logic oscPinOut, compareOutput, compareOutputOe, irq, e;
    int nErrors = 0;
    int nChecks = 0;
    tmr8_row_s rows [9];
    logic [9:0] pins [7];

    always #5 clk = ~clk;

    tmr8_core_model core (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .overflowAck(overflowAck),
        .compareAck(compareAck));

    tmr8_timer uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .overflowAck(overflowAck),
        .compareAck(compareAck), .oscPinIn(oscPinIn),
        .oscPinOut(oscPinOut), .compareOutput(compareOutput),
        .compareOutputOe(compareOutputOe), .irq(irq));

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        core.xfer(1'b1, a, d, q, e);
    endtask : wr

    task rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        core.xfer(1'b0, a, 32'h0, q, e);
        chk(nm, exp, q);
    endtask : rd

    task pinChk(input logic [1:0] exp);
        repeat (3) @(posedge clk);
        #1;
        chk("pin", {30'h0, exp}, {30'h0, compareOutputOe, compareOutput});
    endtask : pinChk

    task summarize;
        if (nErrors == 0 && nChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    initial begin
        #100000;
        nErrors++;
        summarize();
    end

    initial begin
        rows = '{'{`TMR8_OFF_COUNT, 32'h5a, 32'h5a, 1'b0},
            '{`TMR8_OFF_COMPARE, 32'h33, 32'h33, 1'b0},
            '{`TMR8_OFF_IRQEN, 32'h03, 32'h03, 1'b0},
            '{`TMR8_OFF_PORT, 32'h02, 32'h02, 1'b0},
            '{`TMR8_OFF_CTRL, 32'h1b0, 32'hb0, 1'b0},
            '{`TMR8_OFF_FLAGS, 32'h03, 32'h00, 1'b0},
            '{8'h1c, 32'hff, 32'h00, 1'b1},
            '{`TMR8_OFF_CTRL, 32'h00, 32'h00, 1'b0},
            '{`TMR8_OFF_COUNT, 32'hffffff12, 32'h12, 1'b0}};
        // Control word and expected pin level, with direction set
        pins = '{10'h261, 10'h240, 10'h221, 10'h200, 10'h061, 10'h0e1,
            10'h2c1};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("outs", 32'h0, {28'h0, irq, compareOutputOe, compareOutput,
            oscPinOut});
        for (int a = 0; a < 8'h1c; a += 4)
            rd("reset", a[7:0], 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd("row", rows[i].addr, rows[i].rdata);
            chk("slverr", {31'h0, rows[i].err}, {31'h0, e});
        end
        // Stopped timer holds its value
        repeat (20) @(posedge clk);
        rd("held", `TMR8_OFF_COUNT, 32'h12);
        // Count written equal to compare: first match is swallowed
        wr(`TMR8_OFF_COMPARE, 32'h20);
        wr(`TMR8_OFF_COUNT, 32'h20);
        wr(`TMR8_OFF_CTRL, 32'h01);
        rd("blocked", `TMR8_OFF_FLAGS, 32'h0);
        repeat (300) @(posedge clk);
        wr(`TMR8_OFF_CTRL, 32'h00);
        rd("flags", `TMR8_OFF_FLAGS, 32'h3);
        chk("irq", 32'h1, {31'h0, irq});
        core.ack(1'b0, 1'b1);
        rd("cmpack", `TMR8_OFF_FLAGS, 32'h1);
        wr(`TMR8_OFF_FLAGS, 32'h1);
        rd("w1c", `TMR8_OFF_FLAGS, 32'h0);
        repeat (2) @(posedge clk);
        chk("irqoff", 32'h0, {31'h0, irq});
        // Clear on match keeps the count at or below compare
        wr(`TMR8_OFF_COMPARE, 32'h05);
        wr(`TMR8_OFF_COUNT, 32'h00);
        wr(`TMR8_OFF_CTRL, 32'h81);
        repeat (40) @(posedge clk);
        wr(`TMR8_OFF_CTRL, 32'h80);
        core.xfer(1'b0, `TMR8_OFF_COUNT, 32'h0, q, e);
        chk("ctc", 32'h1, {31'h0, q <= 32'h05});
        rd("ctcflag", `TMR8_OFF_FLAGS, 32'h2);
        wr(`TMR8_OFF_CTRL, 32'h81);
        wr(`TMR8_OFF_COUNT, 32'h80);
        wr(`TMR8_OFF_CTRL, 32'h80);
        core.xfer(1'b0, `TMR8_OFF_COUNT, 32'h0, q, e);
        chk("cntwr", 32'h1, {31'h0, q >= 32'h80 && q < 32'h90});
        // Buffered compare: active value stays until the top
        wr(`TMR8_OFF_CTRL, 32'h00);
        wr(`TMR8_OFF_COMPARE, 32'h10);
        wr(`TMR8_OFF_CTRL, 32'h40);
        wr(`TMR8_OFF_COMPARE, 32'h80);
        rd("buffer", `TMR8_OFF_COMPARE, 32'h80);
        wr(`TMR8_OFF_COUNT, 32'h0e);
        wr(`TMR8_OFF_FLAGS, 32'h3);
        wr(`TMR8_OFF_CTRL, 32'h41);
        repeat (10) @(posedge clk);
        wr(`TMR8_OFF_CTRL, 32'h40);
        rd("active", `TMR8_OFF_FLAGS, 32'h2);
        // Output state set up by force before the pin drives
        wr(`TMR8_OFF_FLAGS, 32'h3);
        wr(`TMR8_OFF_CTRL, 32'h00);
        pinChk(2'b01);
        wr(`TMR8_OFF_CTRL, 32'h130);
        wr(`TMR8_OFF_PORT, 32'h01);
        pinChk(2'b11);
        foreach (pins[i]) begin
            wr(`TMR8_OFF_CTRL, {23'h0, pins[i][9:1]});
            pinChk({1'b1, pins[i][0]});
        end
        rd("noflag", `TMR8_OFF_FLAGS, 32'h0);
        // Oscillator pin as the timer base
        wr(`TMR8_OFF_CTRL, 32'h00);
        wr(`TMR8_OFF_COUNT, 32'h00);
        wr(`TMR8_OFF_ASYNC, 32'h01);
        wr(`TMR8_OFF_CTRL, 32'h01);
        repeat (20) @(posedge clk);
        rd("oscidle", `TMR8_OFF_COUNT, 32'h0);
        chk("oscout", 32'h1, {31'h0, oscPinOut});
        repeat (10) begin
            repeat (5) @(posedge clk) oscPinIn <= 1'b1;
            repeat (5) @(posedge clk) oscPinIn <= 1'b0;
        end
        repeat (10) @(posedge clk);
        wr(`TMR8_OFF_CTRL, 32'h00);
        rd("osccount", `TMR8_OFF_COUNT, 32'h0a);
        wr(`TMR8_OFF_ASYNC, 32'h00);
        // Dual slope turns down at the top with no overflow
        wr(`TMR8_OFF_FLAGS, 32'h3);
        wr(`TMR8_OFF_COUNT, 32'hfd);
        wr(`TMR8_OFF_CTRL, 32'hc1);
        repeat (10) @(posedge clk);
        wr(`TMR8_OFF_CTRL, 32'hc0);
        core.xfer(1'b0, `TMR8_OFF_COUNT, 32'h0, q, e);
        chk("phase", 32'h1, {31'h0, q >= 32'hf0 && q < 32'hfe});
        rd("phaseflag", `TMR8_OFF_FLAGS, 32'h0);
        summarize();
    end
endmodule : tb
